// file: verilog/acs_pkg.sv
// Constants, register map and carrier types of the conversion sequencer.
package acs_pkg;

    // ------------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------------
    localparam int unsigned PADDR_W     = 12;
    localparam int unsigned RESULT_W    = 12;
    localparam int unsigned SAMPLE_CYC  = 4;
    localparam int unsigned CONVERT_CYC = 12;
    localparam int unsigned DIV_SEL_W   = 3;
    localparam int unsigned DIV_CNT_W   = 7;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [PADDR_W-1:0] OFS_CTRL0 = 12'h000;
    localparam logic [PADDR_W-1:0] OFS_CTRL1 = 12'h004;
    localparam logic [PADDR_W-1:0] OFS_CTRL2 = 12'h008;
    localparam logic [PADDR_W-1:0] OFS_RESH  = 12'h00C;
    localparam logic [PADDR_W-1:0] OFS_RESL  = 12'h010;
    localparam logic [PADDR_W-1:0] OFS_IRQ   = 12'h014;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTRL0_CH_LSB  = 0;
    localparam int unsigned CTRL0_FMT_BIT = 4;
    localparam int unsigned CTRL0_PWR_BIT = 5;
    localparam int unsigned CTRL0_BSY_BIT = 6;
    localparam int unsigned CTRL0_STA_BIT = 7;
    localparam int unsigned CTRL1_DIV_LSB = 0;
    localparam int unsigned CTRL1_SRC_LSB = 5;
    localparam int unsigned CTRL2_REF_LSB = 0;
    localparam int unsigned IRQ_GIE_BIT   = 0;
    localparam int unsigned IRQ_CIE_BIT   = 1;
    localparam int unsigned IRQ_REQ_BIT   = 2;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [2:0] CH_RST    = 3'h0;
    localparam logic [2:0] SRC_RST   = 3'h0;
    localparam logic [2:0] DIV_RST   = 3'h0;
    localparam logic [3:0] REF_RST   = 4'h0;
    localparam logic [2:0] SRC_EXT_A = 3'h0;
    localparam logic [2:0] SRC_EXT_B = 3'h4;

    // ------------------------------------------------------------------
    // Carrier for the analog front-end controls
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       power_en;
        logic       ext_connect;
        logic [2:0] ext_channel;
        logic [2:0] source;
        logic [3:0] reference;
        logic       sample;
    } acs_analog_t;

endpackage

// file: verilog/acs_sar_core.sv
// Sampling and successive-approximation engine driven by converter clock ticks.
`timescale 1ns/100ps
module acs_sar_core #(
    parameter int unsigned RES_W = 12,
    parameter int unsigned N_SMP = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             tick,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             comp_in,
    output logic                  busy,
    output logic                  sampling,
    output logic                  done,
    output logic [RES_W-1:0]      dac_code,
    output logic [RES_W-1:0]      result
);

    typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_CONVERT} acs_state_t;

    acs_state_t        state;
    logic [4:0]        cnt;
    logic [RES_W-1:0]  trial_bit;

    assign busy     = (state != ACS_IDLE);
    assign sampling = (state == ACS_SAMPLE);

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ACS_IDLE;
            cnt       <= 5'h00;
            trial_bit <= '0;
            dac_code  <= '0;
            done      <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            if (abort) begin
                state <= ACS_IDLE;
            end else if (start) begin
                // A start in any state begins the whole sequence again.
                state    <= ACS_SAMPLE;
                cnt      <= 5'h00;
                dac_code <= '0;
            end else begin
                case (state)
                    ACS_IDLE: begin
                        cnt <= 5'h00;
                    end
                    ACS_SAMPLE: begin
                        if (tick) begin
                            if (cnt == 5'(N_SMP - 1)) begin
                                state                <= ACS_CONVERT;
                                trial_bit            <= '0;
                                trial_bit[RES_W-1]   <= 1'b1;
                                dac_code             <= '0;
                                dac_code[RES_W-1]    <= 1'b1;
                                cnt                  <= 5'h00;
                            end else begin
                                cnt <= cnt + 5'h01;
                            end
                        end
                    end
                    ACS_CONVERT: begin
                        if (tick) begin
                            // Keep the trial bit when the input is at or above the DAC level.
                            if (trial_bit[0]) begin
                                state <= ACS_IDLE;
                                done  <= 1'b1;
                                dac_code <= comp_in ? dac_code : (dac_code & ~trial_bit);
                            end else begin
                                dac_code <= (comp_in ? dac_code : (dac_code & ~trial_bit))
                                            | (trial_bit >> 1);
                            end
                            trial_bit <= trial_bit >> 1;
                        end
                    end
                    default: begin
                        state <= ACS_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= '0;
        end else if (clk_en) begin
            if (!abort && !start && state == ACS_CONVERT && tick && trial_bit[0]) begin
                result <= comp_in ? dac_code : (dac_code & ~trial_bit);
            end
        end
    end

endmodule

// file: verilog/acs_sequencer.sv
// APB register file, converter clock divider, start detection and interrupt request.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module acs_sequencer #(
    parameter int unsigned RES_W = acs_pkg::RESULT_W
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       clk_en,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [acs_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       comp_in,
    output logic      [RES_W-1:0]           dac_code,
    output acs_pkg::acs_analog_t            analog,
    output logic                            conv_irq
);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [2:0]                     ext_channel_sel;
    logic                           result_format_sel;
    logic                           conv_power_enable;
    logic                           start_bit;
    logic                           start_bit_d;
    logic [acs_pkg::DIV_SEL_W-1:0]  conv_clk_div_sel;
    logic [2:0]                     input_source_sel;
    logic [3:0]                     reference_sel;
    logic                           global_irq_enable;
    logic                           conv_irq_enable;
    logic                           conv_irq_flag;
    logic [7:0]                     result_high_byte;
    logic [7:0]                     result_low_byte;

    logic                           wr_en;
    logic                           rd_en;
    logic                           addr_ok;
    logic                           start_pulse;
    logic                           conv_busy_flag;
    logic                           sampling;
    logic                           conv_done;
    logic [RES_W-1:0]               result;
    logic [acs_pkg::DIV_CNT_W-1:0]  div_cnt;
    logic                           conv_tick;
    logic                           ext_path;

    // Terminal count of the converter clock divider for a select code.
    function automatic logic [acs_pkg::DIV_CNT_W-1:0] div_limit(
        input logic [acs_pkg::DIV_SEL_W-1:0] sel
    );
        logic [7:0] full;
        full      = 8'(8'h01 << sel) - 8'h01;
        div_limit = full[acs_pkg::DIV_CNT_W-1:0];
    endfunction

    // True when the source code routes an external channel.
    function automatic logic is_external(input logic [2:0] src);
        is_external = (src == acs_pkg::SRC_EXT_A) || (src == acs_pkg::SRC_EXT_B);
    endfunction

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // The slave answers every access in its first access cycle.
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite && clk_en;
    assign rd_en  = psel && penable && !pwrite;

    always_comb begin
        case (paddr)
            acs_pkg::OFS_CTRL0,
            acs_pkg::OFS_CTRL1,
            acs_pkg::OFS_CTRL2,
            acs_pkg::OFS_RESH,
            acs_pkg::OFS_RESL,
            acs_pkg::OFS_IRQ: addr_ok = 1'b1;
            default:          addr_ok = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_ok;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_channel_sel   <= acs_pkg::CH_RST;
            result_format_sel <= 1'b0;
            conv_power_enable <= 1'b0;
            start_bit         <= 1'b0;
        end else if (wr_en && paddr == acs_pkg::OFS_CTRL0) begin
            ext_channel_sel   <= pwdata[acs_pkg::CTRL0_CH_LSB +: 3];
            result_format_sel <= pwdata[acs_pkg::CTRL0_FMT_BIT];
            conv_power_enable <= pwdata[acs_pkg::CTRL0_PWR_BIT];
            start_bit         <= pwdata[acs_pkg::CTRL0_STA_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_clk_div_sel <= acs_pkg::DIV_RST;
            input_source_sel <= acs_pkg::SRC_RST;
        end else if (wr_en && paddr == acs_pkg::OFS_CTRL1) begin
            conv_clk_div_sel <= pwdata[acs_pkg::CTRL1_DIV_LSB +: acs_pkg::DIV_SEL_W];
            input_source_sel <= pwdata[acs_pkg::CTRL1_SRC_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_sel <= acs_pkg::REF_RST;
        end else if (wr_en && paddr == acs_pkg::OFS_CTRL2) begin
            reference_sel <= pwdata[acs_pkg::CTRL2_REF_LSB +: 4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable <= 1'b0;
            conv_irq_enable   <= 1'b0;
        end else if (wr_en && paddr == acs_pkg::OFS_IRQ) begin
            global_irq_enable <= pwdata[acs_pkg::IRQ_GIE_BIT];
            conv_irq_enable   <= pwdata[acs_pkg::IRQ_CIE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Start detection
    // ------------------------------------------------------------------
    // The fall of the start bit after it was high closes the low-high-low pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_bit_d <= 1'b0;
        end else if (clk_en) begin
            start_bit_d <= start_bit;
        end
    end

    assign start_pulse = start_bit_d && !start_bit && conv_power_enable;

    // ------------------------------------------------------------------
    // Converter clock divider
    // ------------------------------------------------------------------
    // Restarted on each start so the first sampling period is a full one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
        end else if (clk_en) begin
            if (start_pulse || !conv_power_enable || conv_tick) begin
                div_cnt <= '0;
            end else begin
                div_cnt <= div_cnt + 7'h01;
            end
        end
    end

    assign conv_tick = conv_power_enable && (div_cnt == div_limit(conv_clk_div_sel));

    // ------------------------------------------------------------------
    // Conversion engine
    // ------------------------------------------------------------------
    acs_sar_core #(
        .RES_W (RES_W),
        .N_SMP (acs_pkg::SAMPLE_CYC)
    ) u_core (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .tick     (conv_tick),
        .start    (start_pulse),
        .abort    (!conv_power_enable),
        .comp_in  (comp_in),
        .busy     (conv_busy_flag),
        .sampling (sampling),
        .done     (conv_done),
        .dac_code (dac_code),
        .result   (result)
    );

    // ------------------------------------------------------------------
    // Result bytes
    // ------------------------------------------------------------------
    // Format zero left-justifies the value, format one right-justifies it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_high_byte <= 8'h00;
            result_low_byte  <= 8'h00;
        end else if (clk_en) begin
            if (result_format_sel) begin
                result_high_byte <= {4'h0, result[11:8]};
                result_low_byte  <= result[7:0];
            end else begin
                result_high_byte <= result[11:4];
                result_low_byte  <= {result[3:0], 4'h0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    // A conversion end in the same cycle as a software clear keeps the flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_irq_flag <= 1'b0;
        end else if (clk_en) begin
            if (conv_done) begin
                conv_irq_flag <= 1'b1;
            end else if (wr_en && paddr == acs_pkg::OFS_IRQ
                         && !pwdata[acs_pkg::IRQ_REQ_BIT]) begin
                conv_irq_flag <= 1'b0;
            end
        end
    end

    assign conv_irq = global_irq_enable && conv_irq_enable && conv_irq_flag;

    // ------------------------------------------------------------------
    // Analog front-end controls
    // ------------------------------------------------------------------
    assign ext_path = is_external(input_source_sel);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog <= '0;
        end else if (clk_en) begin
            analog.power_en    <= conv_power_enable;
            analog.ext_connect <= conv_power_enable && ext_path;
            analog.ext_channel <= ext_channel_sel;
            analog.source      <= input_source_sel;
            analog.reference   <= reference_sel;
            analog.sample      <= sampling;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Busy is read live so polling sees the end without delay.
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                acs_pkg::OFS_CTRL0: begin
                    prdata[acs_pkg::CTRL0_CH_LSB +: 3]  = ext_channel_sel;
                    prdata[acs_pkg::CTRL0_FMT_BIT]      = result_format_sel;
                    prdata[acs_pkg::CTRL0_PWR_BIT]      = conv_power_enable;
                    prdata[acs_pkg::CTRL0_BSY_BIT]      = conv_busy_flag;
                    prdata[acs_pkg::CTRL0_STA_BIT]      = start_bit;
                end
                acs_pkg::OFS_CTRL1: begin
                    prdata[acs_pkg::CTRL1_DIV_LSB +: acs_pkg::DIV_SEL_W] = conv_clk_div_sel;
                    prdata[acs_pkg::CTRL1_SRC_LSB +: 3]                  = input_source_sel;
                end
                acs_pkg::OFS_CTRL2: begin
                    prdata[acs_pkg::CTRL2_REF_LSB +: 4] = reference_sel;
                end
                acs_pkg::OFS_RESH: begin
                    prdata[7:0] = result_high_byte;
                end
                acs_pkg::OFS_RESL: begin
                    prdata[7:0] = result_low_byte;
                end
                acs_pkg::OFS_IRQ: begin
                    prdata[acs_pkg::IRQ_GIE_BIT] = global_irq_enable;
                    prdata[acs_pkg::IRQ_CIE_BIT] = conv_irq_enable;
                    prdata[acs_pkg::IRQ_REQ_BIT] = conv_irq_flag;
                end
                default: begin
                    prdata = 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

// file: verif/acs_props.sv
// Port assertions for the conversion sequencer.
`timescale 1ns/100ps
module acs_props (
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          clk_en,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [acs_pkg::PADDR_W-1:0]   paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic [31:0]                   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic                          comp_in,
    input wire logic [acs_pkg::RESULT_W-1:0]  dac_code,
    input wire acs_pkg::acs_analog_t          analog,
    input wire logic                          conv_irq
);
    logic       wr_ok;
    logic [9:0] smp_cnt;
    assign wr_ok = psel && penable && pwrite && clk_en;
    // Counts how long the sampling window has stood so far.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) smp_cnt <= 10'h000;
        else if (clk_en) smp_cnt <= analog.sample ? smp_cnt + 10'h001 : 10'h000;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ext_path_a: assert property (analog.ext_connect == (analog.power_en &&
        (analog.source == acs_pkg::SRC_EXT_A || analog.source == acs_pkg::SRC_EXT_B)))
        else $error("external path enable wrong");
    ref_follow_a: assert property (((wr_ok && paddr == acs_pkg::OFS_CTRL2) ##1 clk_en)
        |=> analog.reference == $past(pwdata[3:0], 2)) else $error("reference not applied");
    chan_follow_a: assert property (((wr_ok && paddr == acs_pkg::OFS_CTRL0) ##1 clk_en)
        |=> analog.ext_channel == $past(pwdata[2:0], 2)) else $error("channel not applied");
    src_follow_a: assert property (((wr_ok && paddr == acs_pkg::OFS_CTRL1) ##1 clk_en)
        |=> analog.source == $past(pwdata[7:5], 2)) else $error("source not applied");
    sample_len_a: assert property ($fell(analog.sample) && analog.power_en |-> smp_cnt >= 10'd4)
        else $error("sampling window too short");
    sample_pwr_a: assert property ((!analog.power_en && clk_en) [*3] |-> !analog.sample)
        else $error("sampling without power");
    irq_fall_a: assert property ($fell(conv_irq) |-> $past(wr_ok && paddr == acs_pkg::OFS_IRQ))
        else $error("interrupt dropped without a write");
    freeze_a: assert property (!clk_en |=> $stable(analog) && $stable(dac_code))
        else $error("state moved while frozen");
    rdata_idle_a: assert property (!(psel && penable) |-> prdata == 32'h0 && !pslverr)
        else $error("read bus driven outside access");
    cover property ($fell(analog.sample));
    cover property ($rose(conv_irq));
    cover property (pslverr);
endmodule
bind acs_sequencer acs_props i_acs_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_in(comp_in),
    .dac_code(dac_code), .analog(analog), .conv_irq(conv_irq));

// file: verif/tb_top.sv
// Directed testbench for the conversion sequencer.
`timescale 1ns/100ps
module tb_top;
    logic                 pclk, presetn, clk_en, psel, penable, pwrite, comp_in, e;
    logic                 pready, pslverr, conv_irq;
    logic [11:0]          paddr, dac_code;
    logic [31:0]          pwdata, prdata, q;
    acs_pkg::acs_analog_t analog;
    int                   mismatches, compares, cyc;
    acs_sequencer i_acs_sequencer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comp_in(comp_in), .dac_code(dac_code),
        .analog(analog), .conv_irq(conv_irq));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            print_verdict;
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error land in q and e.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        cmp(q, exp);
        cmp(e, err);
    endtask
    function automatic logic [31:0] ctl0(input logic st, input logic fmt, input logic [2:0] ch);
        return {24'h0, st, 2'b01, fmt, 1'b0, ch};
    endfunction
    task automatic start(input logic fmt, input logic [2:0] ch);
        apb(1'b1, acs_pkg::OFS_CTRL0, ctl0(1'b1, fmt, ch));
        apb(1'b1, acs_pkg::OFS_CTRL0, ctl0(1'b0, fmt, ch));
    endtask
    // Starts a conversion, times the sampling window and the busy span.
    task automatic run_conv(input logic [2:0] dv, input logic fmt);
        int n;
        int t0;
        start(fmt, dv);
        t0 = cyc;
        n = 0;
        while (analog.sample !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (analog.sample === 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        cmp(n, 4 << dv);
        q = 32'h40;
        while (q[6] !== 1'b0 && cyc - t0 < 3000) apb(1'b0, acs_pkg::OFS_CTRL0, 32'h0);
        cmp((cyc - t0 >= (16 << dv)) && (cyc - t0 <= (16 << dv) + 9), 1);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, mismatches, compares, cyc} = '0;
        clk_en = 1'b1;
        comp_in = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd_chk(12'(4 * i), 32'h0, 1'b0);
        rd_chk(12'h018, 32'h0, 1'b1);
        clk_en <= 1'b0;
        apb(1'b1, acs_pkg::OFS_CTRL2, 32'h5);
        clk_en <= 1'b1;
        rd_chk(acs_pkg::OFS_CTRL2, 32'h0, 1'b0);
        $display("test access done");
        // Power the converter up and let it settle before the first start pulse.
        apb(1'b1, acs_pkg::OFS_CTRL0, 32'h20);
        repeat (20) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, acs_pkg::OFS_CTRL1, 32'(i * 33));
            apb(1'b1, acs_pkg::OFS_CTRL2, 32'(2 * i + 1));
            run_conv(3'(i), 1'b0);
            rd_chk(acs_pkg::OFS_RESH, 32'hFF, 1'b0);
            rd_chk(acs_pkg::OFS_RESL, 32'hF0, 1'b0);
            rd_chk(acs_pkg::OFS_IRQ, 32'h4, 1'b0);
            cmp(conv_irq, 32'h0);
            apb(1'b1, acs_pkg::OFS_IRQ, 32'h0);
        end
        $display("test divider done");
        apb(1'b1, acs_pkg::OFS_CTRL0, ctl0(1'b0, 1'b1, 3'h7));
        rd_chk(acs_pkg::OFS_RESH, 32'h0F, 1'b0);
        rd_chk(acs_pkg::OFS_RESL, 32'hFF, 1'b0);
        comp_in <= 1'b0;
        apb(1'b1, acs_pkg::OFS_IRQ, 32'h2);
        apb(1'b1, acs_pkg::OFS_CTRL1, 32'h3);
        run_conv(3'h3, 1'b1);
        rd_chk(acs_pkg::OFS_RESL, 32'h0, 1'b0);
        cmp(conv_irq, 32'h0);
        apb(1'b1, acs_pkg::OFS_IRQ, 32'h7);
        @(posedge pclk);
        cmp(conv_irq, 32'h1);
        $display("test format done");
        start(1'b0, 3'h1);
        repeat (40) @(posedge pclk);
        rd_chk(acs_pkg::OFS_CTRL0, 32'h61, 1'b0);
        run_conv(3'h3, 1'b0);
        apb(1'b1, acs_pkg::OFS_IRQ, 32'h3);
        @(posedge pclk);
        cmp(conv_irq, 32'h0);
        $display("test restart done");
        start(1'b0, 3'h0);
        repeat (6) @(posedge pclk);
        apb(1'b1, acs_pkg::OFS_CTRL0, 32'h0);
        repeat (4) @(posedge pclk);
        rd_chk(acs_pkg::OFS_CTRL0, 32'h0, 1'b0);
        rd_chk(acs_pkg::OFS_IRQ, 32'h3, 1'b0);
        apb(1'b1, acs_pkg::OFS_CTRL0, 32'h80);
        apb(1'b1, acs_pkg::OFS_CTRL0, 32'h0);
        repeat (3) @(posedge pclk);
        rd_chk(acs_pkg::OFS_CTRL0, 32'h0, 1'b0);
        $display("test abort done");
        print_verdict;
    end
endmodule
